/* logic/lwsc_pkg.sv */
// lwsc_pkg: constants for the latency and write-strobe control block.
// assumes a 200 MHz command clock and a classic wishbone register port.
package lwsc_pkg;
  // ****************************************
  // register map (byte addresses)
  // ****************************************
  localparam logic [7:0] ADDR_MODE_REG_TWO = 8'h00;
  localparam logic [7:0] ADDR_MODE_REG_THREE = 8'h04;
  localparam logic [7:0] ADDR_MODE_REG_ELEVEN = 8'h08;
  localparam logic [7:0] ADDR_BAND = 8'h0C;
  localparam logic [7:0] ADDR_LATENCY = 8'h10;
  localparam logic [7:0] ADDR_PRECHARGE = 8'h14;
  localparam logic [7:0] ADDR_STROBE = 8'h18;
  localparam logic [7:0] ADDR_STATUS = 8'h1C;
  // ****************************************
  // field positions
  // ****************************************
  localparam int WL_SET_BIT = 6;
  localparam int RD_INV_BIT = 6;
  localparam int POST_LEN_BIT = 1;
  localparam int TERM_LSB = 0;
  localparam int TERM_W = 3;
  localparam logic [2:0] TERM_OFF = 3'h0;
  localparam int BAND_W = 3;
  localparam int CNT_W = 7;
  localparam logic [31:0] REG_RESET = 32'h0000_0000;
  localparam logic [6:0] BL32_EXTRA = 7'h08;
  localparam logic [31:0] UNMAPPED = 32'h0000_0000;
  // ****************************************
  // band table: index 0 is >10..266 MHz, 7 is >1866..2133 MHz
  // ****************************************
  typedef logic [7:0][6:0] lwsc_col_t;
  localparam lwsc_col_t RL_NOINV = {7'h24, 7'h20, 7'h1C, 7'h18, 7'h14, 7'h0E, 7'h0A, 7'h06};
  localparam lwsc_col_t RL_INV = {7'h28, 7'h24, 7'h20, 7'h1C, 7'h16, 7'h10, 7'h0C, 7'h06};
  localparam lwsc_col_t WL_A = {7'h12, 7'h10, 7'h0E, 7'h0C, 7'h0A, 7'h08, 7'h06, 7'h04};
  localparam lwsc_col_t WL_B = {7'h22, 7'h1E, 7'h1A, 7'h16, 7'h12, 7'h0C, 7'h08, 7'h04};
  localparam lwsc_col_t WR_CNT = {7'h28, 7'h22, 7'h1E, 7'h18, 7'h14, 7'h10, 7'h0A, 7'h06};
  localparam lwsc_col_t RTP_CNT = {7'h10, 7'h0E, 7'h0C, 7'h0A, 7'h08, 7'h08, 7'h08, 7'h08};
  localparam lwsc_col_t SON_A = {7'h08, 7'h06, 7'h06, 7'h04, 7'h04, 7'h00, 7'h00, 7'h00};
  localparam lwsc_col_t SON_B = {7'h18, 7'h14, 7'h12, 7'h0E, 7'h0C, 7'h06, 7'h00, 7'h00};
  localparam lwsc_col_t SOFF_A = {7'h24, 7'h21, 7'h1E, 7'h1B, 7'h18, 7'h15, 7'h12, 7'h0F};
  localparam lwsc_col_t SOFF_B = {7'h34, 7'h2F, 7'h2A, 7'h25, 7'h20, 7'h19, 7'h14, 7'h0F};
  localparam int MHZ_LOW = 10;
  localparam int MHZ_HIGH = 2133;
  // precharge timer state
  typedef enum logic [2:0] {
    PC_IDLE = 3'b001,
    PC_WAIT = 3'b010,
    PC_FIRE = 3'b100
  } lwsc_pc_e;
endpackage : lwsc_pkg

/* logic/lwsc_pc_if.sv */
// lwsc_pc_if: start and done lines between the controller and its precharge timer.
// assumes both ends sit on mclk_in.
`timescale 1ns/100ps
interface lwsc_pc_if;
  logic start;
  logic [6:0] count;
  logic fire;
  logic busy;
  modport ctrl (output start, output count, input fire, input busy);
  modport timer (input start, input count, output fire, output busy);
endinterface : lwsc_pc_if

/* logic/lwsc_pc_timer.sv */
// lwsc_pc_timer: counts a programmed number of cycles, then pulses fire.
// assumes start is a one-cycle pulse from logic on the same clock.
`timescale 1ns/100ps
module lwsc_pc_timer (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  lwsc_pc_if.timer pc
);
  typedef struct packed {
    lwsc_pkg::lwsc_pc_e st;
    logic [6:0] cnt;
  } lwsc_tm_s;
  lwsc_tm_s s_r;
  lwsc_tm_s s_nxt;
  // ****************************************
  // next state
  // ****************************************
  // a new start restarts the count so the latest burst governs the precharge
  always_comb begin
    s_nxt = s_r;
    case (s_r.st)
      lwsc_pkg::PC_IDLE: begin
        if (pc.start) begin
          s_nxt.st = lwsc_pkg::PC_WAIT;
          s_nxt.cnt = pc.count;
        end
      end
      lwsc_pkg::PC_WAIT: begin
        if (pc.start) begin
          s_nxt.cnt = pc.count;
        end else if (s_r.cnt <= 7'h01) begin
          s_nxt.st = lwsc_pkg::PC_FIRE;
        end else begin
          s_nxt.cnt = s_r.cnt - 7'h01;
        end
      end
      // a start on the firing cycle is kept, else that burst would never precharge
      lwsc_pkg::PC_FIRE: begin
        if (pc.start) begin
          s_nxt.st = lwsc_pkg::PC_WAIT;
          s_nxt.cnt = pc.count;
        end else begin
          s_nxt.st = lwsc_pkg::PC_IDLE;
          s_nxt.cnt = 7'h00;
        end
      end
      default: begin
        s_nxt.st = lwsc_pkg::PC_IDLE;
      end
    endcase
  end
  // state register
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      s_r <= '{st: lwsc_pkg::PC_IDLE, cnt: 7'h00};
    end else begin
      s_r <= s_nxt;
    end
  end
  assign pc.fire = (s_r.st == lwsc_pkg::PC_FIRE);
  assign pc.busy = (s_r.st != lwsc_pkg::PC_IDLE);
endmodule : lwsc_pc_timer

/* logic/lwsc_ctrl.sv */
// lwsc_ctrl: latency selection, auto-precharge timing and write-strobe rules.
// assumes a wishbone master on mclk_in and command strobes from logic on mclk_in.
//
// The placing of the registers and the Wishbone register port are this design's own decisions.
`timescale 1ns/100ps
// Summary of operation
// - one frequency band per latency setting
// - read latency from inversion bit column
// - write latency set chosen by select bit
// - write auto-precharge waits write recovery count
// - read auto-precharge waits read-to-precharge count
// - 32-beat bursts add eight cycles to the read-to-precharge count
// - postamble half or one and half cycles
// - strobe scheme read-based or delay-based
// - termination enabled when field nonzero
module lwsc_ctrl #(
  parameter int CNT_W = 7,
  parameter logic [6:0] TURNAROUND = 7'h01,
  parameter logic [6:0] PREAMBLE = 7'h02
) (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [7:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  input wire logic wr_ap_in,
  input wire logic rd_ap_in,
  input wire logic burst32_in,
  input wire logic wr_cmd_in,
  input wire logic [6:0] rtw_extra_in,
  output logic precharge_out,
  output logic strobe_need_out,
  output logic post_long_out,
  output logic term_on_out
);
  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [7:0] mr2;
    logic [7:0] mr3;
    logic [7:0] mode_reg_eleven;
    logic [2:0] band;
    logic scheme;
    logic ack;
    logic [31:0] rdat;
    logic [CNT_W-1:0] son_cnt;
    logic [CNT_W-1:0] soff_cnt;
    logic strobe_need;
  } lwsc_st_s;
  lwsc_st_s s_r;
  lwsc_st_s s_nxt;
  logic [6:0] rl;
  logic [6:0] wl;
  logic [6:0] son;
  logic [6:0] soff;
  logic [6:0] waiver;
  logic [6:0] rtp_eff;
  logic term_on;
  logic [6:0] wv_pos;
  logic [6:0] wv_neg;
  logic req;
  lwsc_pc_if pc_if ();
  // ****************************************
  // latency lookup
  // ****************************************
  // band index selects one row; the host keeps the clock inside that row
  always_comb begin
    rl = s_r.mr3[lwsc_pkg::RD_INV_BIT] ? lwsc_pkg::RL_INV[s_r.band] :
         lwsc_pkg::RL_NOINV[s_r.band];
    wl = s_r.mr2[lwsc_pkg::WL_SET_BIT] ? lwsc_pkg::WL_B[s_r.band] :
         lwsc_pkg::WL_A[s_r.band];
    son = s_r.mr2[lwsc_pkg::WL_SET_BIT] ? lwsc_pkg::SON_B[s_r.band] :
          lwsc_pkg::SON_A[s_r.band];
    soff = s_r.mr2[lwsc_pkg::WL_SET_BIT] ? lwsc_pkg::SOFF_B[s_r.band] :
           lwsc_pkg::SOFF_A[s_r.band];
    rtp_eff = burst32_in ? 7'(lwsc_pkg::RTP_CNT[s_r.band] + lwsc_pkg::BL32_EXTRA) :
              lwsc_pkg::RTP_CNT[s_r.band];
  end
  // termination counts as enabled for any nonzero field value
  assign term_on = s_r.mode_reg_eleven[lwsc_pkg::TERM_LSB +: lwsc_pkg::TERM_W] !=
                   lwsc_pkg::TERM_OFF;
  // waiver period; saturates at zero rather than wrapping
  always_comb begin
    wv_pos = 7'(wl + TURNAROUND);
    wv_neg = 7'(son + PREAMBLE + rtw_extra_in);
    if (term_on) begin
      waiver = TURNAROUND;
    end else if (wv_pos > wv_neg) begin
      waiver = 7'(wv_pos - wv_neg);
    end else begin
      waiver = 7'h00;
    end
  end
  // ****************************************
  // auto-precharge start
  // ****************************************
  // write recovery wins if both arrive together, the later burst rules anyway
  always_comb begin
    pc_if.start = wr_ap_in | rd_ap_in;
    pc_if.count = wr_ap_in ? lwsc_pkg::WR_CNT[s_r.band] : rtp_eff;
  end
  lwsc_pc_timer u_timer (
    .mclk_in(mclk_in),
    .rst_n_in(rst_n_in),
    .pc(pc_if.timer)
  );
  assign req = wb_cyc_in & wb_stb_in;
  // ****************************************
  // registers, bus and strobe window
  // ****************************************
  always_comb begin
    s_nxt = s_r;
    s_nxt.ack = req & ~s_r.ack;
    if (req && !s_r.ack && wb_we_in && wb_sel_in[0]) begin
      if (wb_adr_in == lwsc_pkg::ADDR_MODE_REG_TWO) begin
        s_nxt.mr2 = wb_dat_in[7:0];
      end else if (wb_adr_in == lwsc_pkg::ADDR_MODE_REG_THREE) begin
        s_nxt.mr3 = wb_dat_in[7:0];
      end else if (wb_adr_in == lwsc_pkg::ADDR_MODE_REG_ELEVEN) begin
        s_nxt.mode_reg_eleven = wb_dat_in[7:0];
      end else if (wb_adr_in == lwsc_pkg::ADDR_BAND) begin
        s_nxt.band = wb_dat_in[2:0];
        s_nxt.scheme = wb_dat_in[8];
      end
    end
    s_nxt.rdat = lwsc_pkg::UNMAPPED;
    if (req && !s_r.ack && !wb_we_in) begin
      if (wb_adr_in == lwsc_pkg::ADDR_MODE_REG_TWO) begin
        s_nxt.rdat = {24'h000000, s_r.mr2};
      end else if (wb_adr_in == lwsc_pkg::ADDR_MODE_REG_THREE) begin
        s_nxt.rdat = {24'h000000, s_r.mr3};
      end else if (wb_adr_in == lwsc_pkg::ADDR_MODE_REG_ELEVEN) begin
        s_nxt.rdat = {24'h000000, s_r.mode_reg_eleven};
      end else if (wb_adr_in == lwsc_pkg::ADDR_BAND) begin
        s_nxt.rdat = {23'h000000, s_r.scheme, 5'h00, s_r.band};
      end else if (wb_adr_in == lwsc_pkg::ADDR_LATENCY) begin
        s_nxt.rdat = {17'h00000, wl, 1'b0, rl};
      end else if (wb_adr_in == lwsc_pkg::ADDR_PRECHARGE) begin
        s_nxt.rdat = {17'h00000, rtp_eff, 1'b0, lwsc_pkg::WR_CNT[s_r.band]};
      end else if (wb_adr_in == lwsc_pkg::ADDR_STROBE) begin
        s_nxt.rdat = {9'h000, waiver, 1'b0, soff, 1'b0, son};
      end else if (wb_adr_in == lwsc_pkg::ADDR_STATUS) begin
        s_nxt.rdat = {28'h0000000, s_r.strobe_need, term_on, pc_if.busy,
                      s_r.mr3[lwsc_pkg::POST_LEN_BIT]};
      end
    end
    // delay scheme: strobe expected from on-delay until off-delay after last write
    if (wr_cmd_in && s_r.scheme) begin
      s_nxt.son_cnt = CNT_W'(son);
      s_nxt.soff_cnt = CNT_W'(soff);
      // a later write must not cut the window that an earlier write opened
      s_nxt.strobe_need = s_r.strobe_need | (son == 7'h00);
    end else begin
      if (s_r.son_cnt != '0) begin
        s_nxt.son_cnt = s_r.son_cnt - 1'b1;
        if (s_r.son_cnt == CNT_W'(1)) begin
          s_nxt.strobe_need = 1'b1;
        end
      end
      if (s_r.soff_cnt != '0) begin
        s_nxt.soff_cnt = s_r.soff_cnt - 1'b1;
      end else begin
        s_nxt.strobe_need = 1'b0;
      end
    end
    // read-based scheme: need follows the write command itself
    if (wr_cmd_in && !s_r.scheme) begin
      s_nxt.strobe_need = 1'b1;
      s_nxt.soff_cnt = CNT_W'(soff);
    end
  end
  // state register
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
  assign wb_ack_out = s_r.ack;
  assign wb_dat_out = s_r.rdat;
  assign precharge_out = pc_if.fire;
  assign strobe_need_out = s_r.strobe_need;
  assign post_long_out = s_r.mr3[lwsc_pkg::POST_LEN_BIT];
  assign term_on_out = term_on;
endmodule : lwsc_ctrl

/* verif/lwsc_ctrl_sva.sv */
// lwsc_ctrl_sva: port checks for lwsc_ctrl.
// assumes one clock domain and the single-cycle wishbone answer.
`timescale 1ns/100ps
module lwsc_ctrl_sva (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [7:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  input wire logic [31:0] wb_dat_out,
  input wire logic wb_ack_out,
  input wire logic wr_ap_in,
  input wire logic rd_ap_in,
  input wire logic wr_cmd_in,
  input wire logic precharge_out,
  input wire logic strobe_need_out,
  input wire logic post_long_out,
  input wire logic term_on_out
);
  // ****************************************
  // properties
  // ****************************************
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);
  // a request the slave has not yet answered
  sequence s_req; wb_cyc_in && wb_stb_in && !wb_ack_out; endsequence
  sequence s_wr(a); s_req ##0 (wb_we_in && wb_sel_in[0] && wb_adr_in == a); endsequence
  AST_ACK: assert property (s_req |=> wb_ack_out) else $error("ack late");
  AST_ACK_PULSE: assert property (wb_ack_out |=> !wb_ack_out) else $error("ack held");
  AST_DAT_IDLE: assert property (!wb_ack_out |-> wb_dat_out == 32'h0) else $error("dat");
  // shortest recovery is 6 cycles, so nothing may fire before then
  AST_WR_PC: assert property (wr_ap_in |=> !precharge_out [*6]) else $error("wr pc");
  AST_RD_PC: assert property (
    rd_ap_in && !wr_ap_in |=> !precharge_out [*7]) else $error("rd pc");
  AST_PC_PULSE: assert property ($rose(precharge_out) |=> !precharge_out) else $error("pc");
  AST_TERM: assert property (
    s_wr(8'h08) ##0 wb_dat_in[2:0] != 3'h0 |-> ##[1:3] term_on_out) else $error("term");
  AST_POST: assert property (
    s_wr(8'h04) ##0 wb_dat_in[1] |-> ##[1:3] post_long_out) else $error("post");
  AST_NEED: assert property (wr_cmd_in |-> ##[1:26] strobe_need_out) else $error("need");
endmodule : lwsc_ctrl_sva
bind lwsc_ctrl lwsc_ctrl_sva i_sva (.*);

/* verif/lwsc_host_model.sv */
// lwsc_host_model: host side of the command strobes.
// assumes the bench programs the band before any command.
`timescale 1ns/100ps
module lwsc_host_model (
  input wire logic mclk_in,
  output logic wr_ap_out,
  output logic rd_ap_out,
  output logic wr_cmd_out,
  output logic burst32_out,
  output logic [6:0] rtw_extra_out
);
  // ****************************************
  // command pulses
  // ****************************************
  initial begin
    wr_ap_out = 1'b0;
    rd_ap_out = 1'b0;
    wr_cmd_out = 1'b0;
    burst32_out = 1'b0;
    rtw_extra_out = 7'h00;
  end
  // one-cycle pulse; spacing is the caller's job, command timing wins
  // clock enable stays high and the complement is held high between writes
  // no read burst or turnaround overlaps a write window, so no waiver applies
  // no other toggling is offered to fill the strobe window
  task automatic pulse(input int k);
    @(posedge mclk_in);
    if (k == 0) wr_ap_out <= 1'b1;
    else if (k == 1) rd_ap_out <= 1'b1;
    else wr_cmd_out <= 1'b1;
    @(posedge mclk_in);
    wr_ap_out <= 1'b0;
    rd_ap_out <= 1'b0;
    wr_cmd_out <= 1'b0;
  endtask : pulse
  // burst size and extra read-to-write gap are levels
  task automatic levels(input logic b, input logic [6:0] x);
    @(posedge mclk_in);
    burst32_out <= b;
    rtw_extra_out <= x;
  endtask : levels
endmodule : lwsc_host_model

/* verif/lwsc_ctrl_bench.sv */
// lwsc_ctrl_bench: register and timing bench for lwsc_ctrl.
// assumes lwsc_host_model on the command side and a 200 MHz clock.
`timescale 1ns/100ps
module lwsc_ctrl_bench;
  typedef struct {logic [2:0] band; logic inv; logic sb; logic [31:0] lat; logic [31:0] pre;}
    lwsc_row_s;
  lwsc_row_s rows [16];
  logic mclk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic cyc = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [3:0] msk = 4'hF;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic [31:0] dat_o;
  logic ack, wr_ap, rd_ap, b32, wcmd, pc, need, post, term;
  logic [6:0] rtw;
  int n_errors = 0;
  int total_checks = 0;
  int n;
  lwsc_host_model i_host (.mclk_in(mclk_in), .wr_ap_out(wr_ap), .rd_ap_out(rd_ap),
    .wr_cmd_out(wcmd), .burst32_out(b32), .rtw_extra_out(rtw));
  lwsc_ctrl i_dut (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .wb_cyc_in(cyc), .wb_stb_in(cyc),
    .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat), .wb_dat_out(dat_o),
    .wb_ack_out(ack), .wr_ap_in(wr_ap), .rd_ap_in(rd_ap), .burst32_in(b32), .wr_cmd_in(wcmd),
    .rtw_extra_in(rtw), .precharge_out(pc), .strobe_need_out(need), .post_long_out(post),
    .term_on_out(term));
  // ****************************************
  // tasks
  // ****************************************
  initial forever #2.5 mclk_in = ~mclk_in;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // request held until ack is sampled; read data taken at that same edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_in);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= msk;
    do begin
      @(posedge mclk_in);
    end while (ack !== 1'b1);
    rdat = dat_o;
    cyc <= 1'b0;
  endtask : xfer
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    xfer(1'b0, a, 32'h0);
  endtask : rd
  // sampled 1 ns after each edge, where registered outputs have settled
  task automatic count_to(input bit on_need, input logic lvl, output int c);
    c = 0;
    do begin
      @(posedge mclk_in);
      #1;
      c++;
    end while ((on_need ? need : pc) !== lvl && c < 90);
  endtask : count_to
  task automatic close_out();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : close_out
  initial begin
    #300000;
    n_errors++;
    close_out();
  end
  // ****************************************
  // sequence
  // ****************************************
  initial begin
    // rows cover every band and all four inversion and set combinations
    for (int i = 0; i < 16; i++) begin
      rows[i].band = i[2:0];
      rows[i].inv = i[3];
      rows[i].sb = i[3] ^ i[0];
      rows[i].lat = {17'h0, rows[i].sb ? lwsc_pkg::WL_B[i[2:0]] : lwsc_pkg::WL_A[i[2:0]], 1'b0,
        rows[i].inv ? lwsc_pkg::RL_INV[i[2:0]] : lwsc_pkg::RL_NOINV[i[2:0]]};
      rows[i].pre = {17'h0, lwsc_pkg::RTP_CNT[i[2:0]], 1'b0, lwsc_pkg::WR_CNT[i[2:0]]};
    end
    repeat (2) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    rd(lwsc_pkg::ADDR_STATUS);
    chk(rdat, 32'h0);
    foreach (rows[i]) begin
      wr(lwsc_pkg::ADDR_BAND, 32'(rows[i].band));
      wr(lwsc_pkg::ADDR_MODE_REG_TWO, 32'(rows[i].sb) << 6);
      wr(lwsc_pkg::ADDR_MODE_REG_THREE, 32'(rows[i].inv) << 6);
      rd(lwsc_pkg::ADDR_LATENCY);
      chk(rdat, rows[i].lat);
      rd(lwsc_pkg::ADDR_PRECHARGE);
      chk(rdat, rows[i].pre);
    end
    // read-only target, dead byte lane and a hole in the map change nothing
    wr(lwsc_pkg::ADDR_LATENCY, 32'hFFFF_FFFF);
    rd(lwsc_pkg::ADDR_LATENCY);
    chk(rdat, rows[15].lat);
    msk = 4'h0;
    wr(lwsc_pkg::ADDR_MODE_REG_TWO, 32'h40);
    msk = 4'hF;
    rd(lwsc_pkg::ADDR_MODE_REG_TWO);
    chk(rdat, 32'h0);
    rd(8'h40);
    chk(rdat, 32'h0);
    // auto-precharge timing in band 2, long burst on the read side
    wr(lwsc_pkg::ADDR_BAND, 32'h2);
    i_host.pulse(0);
    count_to(1'b0, 1'b1, n);
    chk(n, 32'(lwsc_pkg::WR_CNT[2]));
    i_host.levels(1'b1, 7'h2);
    i_host.pulse(1);
    count_to(1'b0, 1'b1, n);
    chk(n, 32'(lwsc_pkg::RTP_CNT[2] + lwsc_pkg::BL32_EXTRA));
    // band 4 set B, delay scheme: waiver 22 - 14 + 1 - 2 - 2 = 5
    wr(lwsc_pkg::ADDR_BAND, 32'h104);
    wr(lwsc_pkg::ADDR_MODE_REG_TWO, 32'h40);
    rd(lwsc_pkg::ADDR_STROBE);
    chk(rdat, {9'h0, 7'h5, 1'b0, lwsc_pkg::SOFF_B[4], 1'b0, lwsc_pkg::SON_B[4]});
    i_host.levels(1'b0, 7'h7);
    rd(lwsc_pkg::ADDR_STROBE);
    chk(32'(rdat[22:16]), 32'h0);
    wr(lwsc_pkg::ADDR_MODE_REG_ELEVEN, 32'h1);
    rd(lwsc_pkg::ADDR_STROBE);
    chk(32'(rdat[22:16]), 32'h1);
    chk({31'h0, term}, 32'h1);
    i_host.pulse(2);
    count_to(1'b1, 1'b1, n);
    chk(n, 32'(lwsc_pkg::SON_B[4]));
    count_to(1'b1, 1'b0, n);
    chk({31'h0, need}, 32'h0);
    // window from command to release covers at least the off delay, one cycle spare at most
    n = n + int'(lwsc_pkg::SON_B[4]);
    chk(32'(n >= int'(lwsc_pkg::SOFF_B[4]) && n <= int'(lwsc_pkg::SOFF_B[4]) + 1), 32'h1);
    // read-based scheme asks for the strobe straight away
    wr(lwsc_pkg::ADDR_BAND, 32'h4);
    i_host.pulse(2);
    count_to(1'b1, 1'b1, n);
    chk(32'(n <= 1), 32'h1);
    wr(lwsc_pkg::ADDR_MODE_REG_THREE, 32'h2);
    rd(lwsc_pkg::ADDR_STATUS);
    chk({31'h0, rdat[0]}, 32'h1);
    chk({31'h0, post}, 32'h1);
    // second reset mid-run clears the mode registers
    @(posedge mclk_in);
    rst_n_in <= 1'b0;
    repeat (2) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    rd(lwsc_pkg::ADDR_MODE_REG_THREE);
    chk(rdat, 32'h0);
    chk({31'h0, term}, 32'h0);
    close_out();
  end
endmodule : lwsc_ctrl_bench
